// >>> hw/aavg_pkg.sv
// Package: register map, field layout and carrier types of the averaging block
package aavg_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00; // Enable and software reset command
   localparam logic [7:0] OFF_INPUT = 8'h04; // Input selection control
   localparam logic [7:0] OFF_THIRD_CONTROL_REGISTER = 8'h08; // Third control register
   localparam logic [7:0] OFF_AVG = 8'h0C; // Averaging control
   localparam logic [7:0] OFF_SAMP = 8'h10; // Sampling time control
   localparam logic [7:0] OFF_TRIG = 8'h14; // Software trigger
   localparam logic [7:0] OFF_GAIN = 8'h18; // Gain correction
   localparam logic [7:0] OFF_OFFS = 8'h1C; // Offset correction
   localparam logic [7:0] OFF_WINDOW_LOWER_THRESHOLD = 8'h20; // Window lower threshold
   localparam logic [7:0] OFF_WINDOW_UPPER_THRESHOLD = 8'h24; // Window upper threshold
   localparam logic [7:0] OFF_INT_EN = 8'h28; // Interrupt enable
   localparam logic [7:0] OFF_INT_CLR = 8'h2C; // Interrupt clear, write only
   localparam logic [7:0] OFF_INT_ST = 8'h30; // Interrupt status, read only
   localparam logic [7:0] OFF_RESULT = 8'h34; // Conversion result
   localparam logic [7:0] OFF_BUSY = 8'h38; // Sync busy status
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_EN_BIT = 0; // Enable
   localparam int CTRL_SOFTWARE_RESET_CMD_BIT = 1; // Software reset command
   localparam int AVG_SNUM_LSB = 0; // Sample count select, 4 bits
   localparam int AVG_ADJ_LSB = 4; // Result adjust shift, 3 bits
   localparam int THIRD_CONTROL_REGISTER_RES_LSB = 4; // Resolution select, 2 bits
   localparam int INT_RESULT_READY_FLAG_BIT = 0; // Result ready flag
   // Sync busy bit positions
   localparam int SB_SOFTWARE_RESET_CMD = 0;
   localparam int SB_ENABLE = 1;
   localparam int SB_INPUT = 2;
   localparam int SB_THIRD_CONTROL_REGISTER = 3;
   localparam int SB_AVG = 4;
   localparam int SB_SAMP = 5;
   localparam int SB_WINDOW_LOWER_THRESHOLD = 6;
   localparam int SB_WINDOW_UPPER_THRESHOLD = 7;
   localparam int SB_GAIN = 8;
   localparam int SB_OFFS = 9;
   localparam int SB_TRIG = 10;
   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam logic [15:0] BUSY_RST = 16'h0000; // Nothing crossing
   localparam logic [3:0] SNUM_MAX = 4'hA; // 1024 samples
   localparam logic [3:0] SNUM_NOSHIFT = 4'h4; // Up to 16 samples no auto shift
   localparam int ACC_W = 22; // 12-bit samples times 1024
   // Bus request carrier
   typedef struct packed {
      logic read; // Read strobe
      logic write; // Write strobe
      logic [7:0] address; // Byte address
      logic [31:0] writedata; // Write data
   } aavg_req_t;
endpackage

// >>> hw/aavg_top.sv
// Averaging post-processor with sync busy status behind an Avalon-MM slave
//
// Chosen here: the Avalon-MM register port and the register addresses.
module aavg_top
   import aavg_pkg::*;
(
   input wire logic clock, // 40 MHz clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic ce, // Clock enable, freezes all state
   input wire aavg_pkg::aavg_req_t req, // Avalon-MM request
   output logic waitrequest, // Avalon-MM wait
   output logic [31:0] readdata, // Avalon-MM read data
   input wire logic sample_valid, // Raw conversion strobe
   input wire logic [11:0] sample, // Raw conversion value
   output logic irq // Level interrupt
);
   import aavg_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic en; // Converter enabled
      logic [3:0] snum; // Sample count select
      logic [2:0] adj; // Result adjust shift
      logic [1:0] resolution_select; // Resolution select
      logic [ACC_W-1:0] acc; // Running sum
      logic [10:0] cnt; // Samples taken in this group
      logic [15:0] result; // Posted result
      logic [15:0] busy; // Sync busy bits
      logic [15:0] pend1; // Crossing, first stage
      logic [15:0] pend2; // Crossing, second stage
      logic int_st; // Sticky result ready
      logic int_en; // Result ready enable
      logic ack; // Bus answer cycle
      logic [31:0] rdata; // Read data register
   } aavg_state_t;

   aavg_state_t q; // Registered state
   aavg_state_t d; // Next state

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Last sample index of a group; reserved codes act as one sample
   function automatic logic [10:0] last_idx(input logic [3:0] s);
      logic [10:0] r;
      r = 11'h000;
      if (s <= SNUM_MAX)
      begin
         r = 11'((12'h001 << s) - 12'h001);
      end
      return r;
   endfunction

   // Automatic right shifts that keep the intermediate at 16 bits
   function automatic logic [3:0] auto_shift(input logic [3:0] s);
      logic [3:0] r;
      r = 4'h0;
      if (s > SNUM_NOSHIFT && s <= SNUM_MAX)
      begin
         r = s - SNUM_NOSHIFT;
      end
      return r;
   endfunction

   // Busy bits that a write to an address launches
   function automatic logic [15:0] busy_mask(input logic [7:0] a, input logic [31:0] w);
      logic [15:0] m;
      m = 16'h0000;
      unique case (a)
         OFF_CTRL:
         begin
            m[SB_ENABLE] = 1'b1;
            m[SB_SOFTWARE_RESET_CMD] = w[CTRL_SOFTWARE_RESET_CMD_BIT];
         end
         OFF_INPUT: m[SB_INPUT] = 1'b1;
         OFF_THIRD_CONTROL_REGISTER: m[SB_THIRD_CONTROL_REGISTER] = 1'b1;
         OFF_AVG: m[SB_AVG] = 1'b1;
         OFF_SAMP: m[SB_SAMP] = 1'b1;
         OFF_WINDOW_LOWER_THRESHOLD: m[SB_WINDOW_LOWER_THRESHOLD] = 1'b1;
         OFF_WINDOW_UPPER_THRESHOLD: m[SB_WINDOW_UPPER_THRESHOLD] = 1'b1;
         OFF_GAIN: m[SB_GAIN] = 1'b1;
         OFF_OFFS: m[SB_OFFS] = 1'b1;
         OFF_TRIG: m[SB_TRIG] = 1'b1;
         default: m = 16'h0000;
      endcase
      return m;
   endfunction

   // ----------------------------------------
   // Combinational helpers
   // ----------------------------------------
   logic wr_ok; // Write takes effect this cycle
   logic take; // Sample accepted
   logic done; // Group complete
   logic [ACC_W-1:0] sum; // Running sum with new sample
   logic [15:0] inter; // Intermediate after auto shift
   logic [15:0] final_val; // Result after adjust shift
   logic software_reset_cmd; // Software reset command

   // Bus waits one cycle, answers on the second
   assign waitrequest = (req.read | req.write) & ~q.ack;
   assign wr_ok = req.write & q.ack;
   assign software_reset_cmd = wr_ok && req.address == OFF_CTRL && req.writedata[CTRL_SOFTWARE_RESET_CMD_BIT];
   assign take = sample_valid & q.en;
   assign sum = q.acc + ACC_W'(sample);
   assign done = take && q.cnt == last_idx(q.snum);
   assign inter = 16'(sum >> auto_shift(q.snum));
   assign final_val = inter >> q.adj;
   assign readdata = q.rdata;
   assign irq = q.int_st & q.int_en;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      d = q;
      d.ack = (req.read | req.write) & ~q.ack;
      // Read data captured in the wait cycle
      if (req.read && !q.ack)
      begin
         unique case (req.address)
            OFF_CTRL: d.rdata = {31'h0000_0000, q.en};
            OFF_THIRD_CONTROL_REGISTER: d.rdata = {26'h000_0000, q.resolution_select, 4'h0};
            OFF_AVG: d.rdata = {25'h000_0000, q.adj, q.snum};
            OFF_INT_EN: d.rdata = {31'h0000_0000, q.int_en};
            OFF_INT_ST: d.rdata = {31'h0000_0000, q.int_st};
            OFF_RESULT: d.rdata = {16'h0000, q.result};
            OFF_BUSY: d.rdata = {16'h0000, q.busy};
            default: d.rdata = 32'h0000_0000;
         endcase
      end
      // Register writes
      if (wr_ok)
      begin
         unique case (req.address)
            OFF_CTRL: d.en = req.writedata[CTRL_EN_BIT];
            OFF_THIRD_CONTROL_REGISTER: d.resolution_select = req.writedata[THIRD_CONTROL_REGISTER_RES_LSB +: 2];
            OFF_AVG:
            begin
               d.snum = req.writedata[AVG_SNUM_LSB +: 4];
               d.adj = req.writedata[AVG_ADJ_LSB +: 3];
               d.acc = '0;
               d.cnt = 11'h000;
            end
            OFF_INT_EN: d.int_en = req.writedata[INT_RESULT_READY_FLAG_BIT];
            OFF_INT_CLR:
            begin
               if (req.writedata[INT_RESULT_READY_FLAG_BIT])
               begin
                  d.int_st = 1'b0;
               end
            end
            default: d.rdata = d.rdata;
         endcase
      end
      // Accumulate samples, post on the last of the group
      if (take)
      begin
         if (done)
         begin
            d.result = final_val;
            d.acc = '0;
            d.cnt = 11'h000;
            d.int_st = 1'b1;
         end
         else
         begin
            d.acc = sum;
            d.cnt = q.cnt + 11'h001;
         end
      end
      // Software reset clears configuration and data path
      if (software_reset_cmd)
      begin
         d.en = 1'b0;
         d.snum = 4'h0;
         d.adj = 3'h0;
         d.resolution_select = 2'h0;
         d.acc = '0;
         d.cnt = 11'h000;
         d.result = 16'h0000;
         d.int_st = 1'b0;
         d.int_en = 1'b0;
      end
      // Crossing pipeline; a new launch wins over completion
      d.pend1 = wr_ok ? busy_mask(req.address, req.writedata) : 16'h0000;
      d.pend2 = q.pend1;
      d.busy = (q.busy & ~q.pend2) | d.pend1;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else if (ce)
      begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock iff ce);
   endclocking
   default disable iff (rst);

   property p_single;
      (take && q.snum == 4'h0 && !software_reset_cmd) |=> q.int_st && q.result == {4'h0, $past(sample)};
   endproperty
   a_single: assert property (p_single) else $error("single sample result wrong");

   property p_cnt_bound;
      q.cnt <= last_idx(q.snum);
   endproperty
   a_cnt_bound: assert property (p_cnt_bound) else $error("sample count overrun");

   property p_post_rate;
      ($changed(q.result) && !$past(software_reset_cmd)) |-> $past(done);
   endproperty
   a_post_rate: assert property (p_post_rate) else $error("result posted mid group");

   property p_div32;
      (done && q.snum == 4'h5 && q.adj == 3'h4 && !software_reset_cmd)
         |=> q.result == 16'($past(sum) >> 5);
   endproperty
   a_div32: assert property (p_div32) else $error("32 sample average wrong");

   property p_flag;
      (done && !software_reset_cmd) |=> q.int_st ##0 irq == q.int_en;
   endproperty
   a_flag: assert property (p_flag) else $error("result ready not raised");

   property p_avg_busy;
      (wr_ok && req.address == OFF_AVG) |=> q.busy[SB_AVG] ##1 q.busy[SB_AVG];
   endproperty
   a_avg_busy: assert property (p_avg_busy) else $error("averaging busy missing");

   property p_gain_clear;
      (wr_ok && req.address == OFF_GAIN) ##1 (!wr_ok) [*2] |=> !q.busy[SB_GAIN];
   endproperty
   a_gain_clear: assert property (p_gain_clear) else $error("gain busy stuck");

   property p_window_upper_threshold;
      (wr_ok && req.address == OFF_WINDOW_UPPER_THRESHOLD && !q.busy[SB_WINDOW_LOWER_THRESHOLD])
         |=> q.busy[SB_WINDOW_UPPER_THRESHOLD] && !q.busy[SB_WINDOW_LOWER_THRESHOLD];
   endproperty
   a_window_upper_threshold: assert property (p_window_upper_threshold) else $error("threshold busy bit wrong");

   // Offset write raises its own bit and leaves the trigger bit to its own crossing
   property p_offs;
      (wr_ok && req.address == OFF_OFFS)
         |=> q.busy[SB_OFFS] && q.busy[SB_TRIG] == $past(q.busy[SB_TRIG] & ~q.pend2[SB_TRIG]);
   endproperty
   a_offs: assert property (p_offs) else $error("offset busy missing");

   property p_software_reset_cmd_busy;
      software_reset_cmd |=> q.busy[SB_SOFTWARE_RESET_CMD] && q.busy[SB_ENABLE] && !q.en;
   endproperty
   a_software_reset_cmd_busy: assert property (p_software_reset_cmd_busy) else $error("reset busy missing");

   property p_upper_zero;
      q.busy[15:11] == 5'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper busy bits set");

   // Writes to the result register must never disturb the posted average
   property p_ro_result;
      (wr_ok && req.address == OFF_RESULT && !done) |=> $stable(q.result);
   endproperty
   a_ro_result: assert property (p_ro_result) else $error("result overwritten by bus");

   // A clear with no new result in the same cycle drops the ready flag
   property p_int_clear;
      (wr_ok && req.address == OFF_INT_CLR && req.writedata[INT_RESULT_READY_FLAG_BIT] && !done)
         |=> !q.int_st;
   endproperty
   a_int_clear: assert property (p_int_clear) else $error("ready flag not cleared");

   // Main scenarios worth seeing: long groups, reserved codes, races
   c_avg32: cover property (done && q.snum == 4'h5);
   c_clear_race: cover property (done && wr_ok && req.address == OFF_INT_CLR);
   c_busy_seen: cover property (req.read && req.address == OFF_BUSY && q.busy != 16'h0000);
   c_avg1024: cover property (done && q.snum == SNUM_MAX);
   c_reserved: cover property (done && q.snum > SNUM_MAX);
endmodule

// >>> sim/aavg_adc_model.sv
// Behavioural raw-sample source standing in for the conversion core
module aavg_adc_model
(
   input wire logic clock, // Shared clock
   input wire logic rst, // Synchronous reset
   input wire logic go, // Load a new burst
   input wire logic [10:0] num, // Samples in the burst
   input wire logic [11:0] first, // First value, later ones count up
   input wire logic [1:0] gap, // Idle cycles between samples
   output logic sample_valid, // One-cycle conversion strobe
   output logic [11:0] sample, // Conversion value
   output logic pending // Burst still running
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] left_q; // Samples still to send
   logic [11:0] val_q; // Next value to send
   logic [1:0] wait_q; // Gap countdown
   assign pending = (left_q != 11'h000) || sample_valid;
   // Emit samples; idle data toggles so a stale value never looks valid
   always @(posedge clock)
   begin
      if (rst)
      begin
         left_q <= 11'h000;
         sample_valid <= 1'b0;
         sample <= 12'h000;
         wait_q <= 2'h0;
      end
      else if (go)
      begin
         left_q <= num;
         val_q <= first;
      end
      else if (left_q != 11'h000 && wait_q == 2'h0)
      begin
         sample_valid <= 1'b1;
         sample <= val_q;
         val_q <= val_q + 12'h001;
         left_q <= left_q - 11'h001;
         wait_q <= gap;
      end
      else
      begin
         sample_valid <= 1'b0;
         sample <= ~sample;
         if (wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
      end
   end
endmodule

// >>> sim/aavg_top_tb.sv
// Self-checking bench: register bus tasks, busy table, averaging runs
module aavg_top_tb
   import aavg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rst = 1'b1, ce = 1'b1, go = 1'b0; // Bench drives
   aavg_req_t req = '0; // Bus request
   logic waitrequest, irq, sample_valid, pending; // Design and model outputs
   logic [31:0] readdata, rd; // Read data and last value taken
   logic [11:0] sample, first = 12'h000; // Sample lines
   logic [10:0] num = 11'h000; // Burst length
   logic [1:0] gap = 2'h0; // Burst spacing
   int bad_count = 0, checks_done = 0; // Counters
   logic [7:0] ta [11] = '{OFF_CTRL, OFF_CTRL, OFF_INPUT, OFF_THIRD_CONTROL_REGISTER, OFF_AVG, OFF_SAMP,
      OFF_WINDOW_LOWER_THRESHOLD, OFF_WINDOW_UPPER_THRESHOLD, OFF_GAIN, OFF_OFFS, OFF_TRIG}; // Busy table addresses
   logic [31:0] td [11] = '{32'h0000_0002, 32'h0000_0001, 0, 32'h0000_0010, 0, 0, 0, 0, 0, 0, 0};
   logic [31:0] te [11] = '{32'h0000_0003, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008,
      32'h0000_0010, 32'h0000_0020, 32'h0000_0040, 32'h0000_0080, 32'h0000_0100,
      32'h0000_0200, 32'h0000_0400}; // Expected busy pattern per write
   logic [3:0] cs [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hA, 4'hB}; // Codes run
   logic [3:0] c; // Current code
   logic [2:0] adj; // Extra shift
   logic [10:0] n; // Samples per result
   logic [31:0] exp; // Expected average
   int sh, sum; // Auto shift and running sum
   always #12.5 clock = ~clock;
   aavg_top aavg_top_inst (.clock(clock), .rst(rst), .ce(ce), .req(req),
      .waitrequest(waitrequest), .readdata(readdata), .sample_valid(sample_valid),
      .sample(sample), .irq(irq));
   aavg_adc_model aavg_adc_model_inst (.clock(clock), .rst(rst), .go(go), .num(num),
      .first(first), .gap(gap), .sample_valid(sample_valid), .sample(sample),
      .pending(pending));
   // Compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask
   // Print counts and verdict
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One bus access; request held until waitrequest is sampled low
   task automatic bus_op(input logic is_rd, input logic [7:0] a, input logic [31:0] d);
      logic w;
      int k;
      k = 0;
      req <= '{read: is_rd, write: !is_rd, address: a, writedata: d};
      do
      begin
         @(posedge clock);
         w = waitrequest;
         rd = readdata;
         k++;
      end
      while (w !== 1'b0 && k < 100);
      if (w !== 1'b0)
      begin
         bad_count++;
         conclude();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_op(1'b0, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] want, input string what);
      bus_op(1'b1, a, 32'h0000_0000);
      check(what, rd, want);
   endtask
   // Release the bus, let registered outputs settle, then look at irq
   task automatic irqchk(input logic want);
      req <= '0;
      repeat (2) @(posedge clock);
      @(negedge clock);
      check("irq", {31'h0, irq}, {31'h0, want});
      @(posedge clock);
   endtask
   // Run one burst from the sample source and wait for it to finish
   task automatic burst(input logic [10:0] bn, input logic [11:0] f, input logic [1:0] g);
      int k;
      req <= '0;
      num <= bn;
      first <= f;
      gap <= g;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      k = 0;
      do
      begin
         @(negedge clock);
         k++;
      end
      while (pending && k < 5000);
      if (pending)
      begin
         bad_count++;
         conclude();
      end
      @(posedge clock);
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rdchk(OFF_BUSY, 0, "busy reset");
      rdchk(OFF_RESULT, 0, "result reset");
      rdchk(8'h3C, 0, "unmapped");
      $display("test reset done");
      // Each write raises exactly its own busy bit, a reset write also the enable bit, gone two cycles later
      for (int i = 0; i < 11; i++)
      begin
         wr(ta[i], td[i]);
         rdchk(OFF_BUSY, te[i], "busy set");
         rdchk(OFF_BUSY, 0, "busy clear");
      end
      wr(OFF_BUSY, 32'hFFFF_FFFF);
      rdchk(OFF_BUSY, 0, "busy read only");
      rdchk(OFF_THIRD_CONTROL_REGISTER, 32'h0000_0010, "resolution");
      rdchk(OFF_CTRL, 32'h0000_0001, "enable");
      $display("test busy done");
      wr(OFF_INT_EN, 32'h0000_0001);
      rdchk(OFF_INT_EN, 32'h0000_0001, "irq enable");
      // Averaging over count codes 0 to 5, 10 and 11, reserved code 11 acting as one sample
      for (int i = 0; i < 8; i++)
      begin
         c = cs[i];
         n = (c <= 4'hA) ? (11'h001 << c) : 11'h001;
         adj = (c > 4'hA) ? 3'h0 : ((c < 4'h4) ? c[2:0] : 3'h4);
         sh = (c > 4'h4 && c <= 4'hA) ? int'(c) - 4 : 0;
         sum = 0;
         for (int k = 0; k < n; k++)
            sum += 32'h0000_0300 + c + k;
         exp = ((sum >> sh) & 32'h0000_FFFF) >> adj;
         wr(OFF_INT_CLR, 32'h0000_0001);
         wr(OFF_AVG, {25'h0, adj, c});
         if (n > 11'h001)
         begin
            burst(n - 11'h001, {8'h30, c}, 2'(i % 3));
            rdchk(OFF_INT_ST, 0, "flag early");
         end
         burst(11'h001, {8'h30, c} + 12'(n) - 12'h001, 2'h0);
         irqchk(1'b1);
         rdchk(OFF_RESULT, exp, "average");
         rdchk(OFF_INT_ST, 1, "ready flag");
      end
      rdchk(OFF_AVG, {25'h0, adj, c}, "averaging control");
      wr(OFF_RESULT, 32'hFFFF_FFFF);
      rdchk(OFF_RESULT, exp, "result read only");
      $display("test averaging done");
      wr(OFF_INT_EN, 0);
      irqchk(1'b0);
      rdchk(OFF_INT_ST, 1, "flag sticky");
      wr(OFF_INT_EN, 32'h0000_0001);
      irqchk(1'b1);
      wr(OFF_INT_CLR, 32'h0000_0001);
      rdchk(OFF_INT_ST, 0, "flag cleared");
      irqchk(1'b0);
      $display("test interrupt done");
      // Clock enable low: a sample arriving then must leave no trace
      ce <= 1'b0;
      burst(11'h001, 12'hABC, 2'h0);
      ce <= 1'b1;
      rdchk(OFF_RESULT, exp, "frozen result");
      rdchk(OFF_INT_ST, 0, "frozen flag");
      $display("test clock enable done");
      conclude();
   end
endmodule
